// ==== design/tosac_pkg.sv ====
// Constants and carrier types of the one-shot and capture timer.
// Assumes a 3-bit word address and 16-bit data on the register port.
package tosac_pkg;
  // Register word offsets
  localparam logic [2:0] OFF_CTRL0 = 3'h0;
  localparam logic [2:0] OFF_CTRL1 = 3'h1;
  localparam logic [2:0] OFF_COUNT = 3'h2;
  localparam logic [2:0] OFF_CMPA = 3'h3;
  localparam logic [2:0] OFF_STAT = 3'h4;
  localparam logic [2:0] OFF_CLR = 3'h5;
  localparam logic [2:0] OFF_IEN = 3'h6;
  // Control word 0 fields
  localparam int C0_RUN = 0;
  localparam int C0_PER = 1;
  localparam int C0_CLK = 4;
  // Control word 1 fields
  localparam int C1_MODE = 0;
  localparam int C1_PFN = 2;
  localparam int C1_OINIT = 4;
  localparam int C1_OPOL = 5;
  localparam int C1_SWAP = 6;
  localparam int C1_CLRSEL = 7;
  localparam int C1_CAPSEL = 8;
  localparam int C1_TFALL = 9;
  // Status bit positions
  localparam int ST_A = 0;
  localparam int ST_P = 1;
  // Mode and pin function codes
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h2;
  localparam logic [1:0] PF_RISE = 2'h0;
  localparam logic [1:0] PF_FALL = 2'h1;
  localparam logic [1:0] PF_BOTH = 2'h2;
  localparam logic [1:0] PF_PULSE = 2'h3;
  // Counter limits and prescale masks
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  localparam logic [3:0] DIV4_MASK = 4'h3;
  localparam logic [3:0] DIV16_MASK = 4'hF;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [15:0] wdata;
  } tosac_bus_req_type;

  typedef struct packed {
    logic run;
    logic [2:0] period;
    logic [1:0] clk_sel;
    logic [1:0] mode;
    logic [1:0] pin_fn;
    logic out_init;
    logic out_pol;
    logic swap;
    logic clr_sel;
    logic cap_sel;
    logic trig_fall;
    logic [9:0] count;
    logic [9:0] cmp_a;
    logic [1:0] stat;
    logic [1:0] irq_en;
    logic [3:0] presc;
    logic trig_prev;
    logic cap_prev;
    logic timer_out;
    logic out_en;
    logic irq;
    logic [15:0] rd_data;
  } tosac_state_type;
endpackage : tosac_pkg

// ==== design/tosac_timer.sv ====
// One-shot pulse and capture timer with register port and interrupt.
// Assumes all pins synchronous to clk and a one-cycle strobe master.
// Function
// - Mode 10 with pin function 11 selects single pulse output.
// - Run bit rising starts counter and drives pulse leading edge.
// - Trigger pin active edge sets run bit in single pulse mode.
// - Software clearing run bit ends the pulse.
// - Compare A match clears run, stops counter, ends pulse, flags interrupt.
// - Single pulse counter returns to zero only when run rises.
// - Period compare, clear select and swap ignored in single pulse.
// - Mode 01 selects capture input operation.
// - Capture counter starts from zero when run bit rises.
// - Active capture edge copies counter into compare A, flags interrupt.
// - Capture counter keeps running until run bit falls.
// - Period match in capture resets counter and flags interrupt.
// - Zero period value lets counter run to full count.
// - Pin function 11 in capture mode disables captures only.
// - Capture pin watched even when shared pin drives out.
// - Capture ignores clear select, swap, initial level, polarity; no output.
`timescale 1ns/1ps
`default_nettype none
module tosac_timer (
  input wire logic clk,
  input wire logic rst_b,
  input wire tosac_pkg::tosac_bus_req_type bus_req,
  output logic [15:0] rd_data,
  input wire logic external_trigger_pin,
  input wire logic capture_pin_first,
  input wire logic capture_pin_second,
  output logic timer_out,
  output logic timer_out_en,
  output logic irq
);
  tosac_pkg::tosac_state_type st_q;
  tosac_pkg::tosac_state_type st_d;
  logic [1:0] rst_sync_q;
  logic rst_ok_b;
  logic tick;
  logic sp;
  logic cap;
  logic trig_edge;
  logic cap_lvl;
  logic cap_edge;
  logic count_en;
  logic match_a;
  logic per_match;
  logic wr_c0;
  logic wr_c1;
  logic wr_cmpa;
  logic wr_clr;
  logic [9:0] nxt;
  logic [15:0] w;

  // Reset released through two flops so the state sees a clean edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_ok_b = rst_sync_q[1];

  // Next state of the whole timer
  always_comb begin
    st_d = st_q;
    w = bus_req.wdata;
    // Prescaler enable; code 3 stops the counter
    case (st_q.clk_sel)
      2'h0: begin
        tick = 1'b1;
      end
      2'h1: begin
        tick = (st_q.presc & tosac_pkg::DIV4_MASK) == tosac_pkg::DIV4_MASK;
      end
      2'h2: begin
        tick = st_q.presc == tosac_pkg::DIV16_MASK;
      end
      default: begin
        tick = 1'b0;
      end
    endcase
    st_d.presc = st_q.presc + 4'h1;
    sp = st_q.mode == tosac_pkg::MODE_PULSE && st_q.pin_fn == tosac_pkg::PF_PULSE;
    cap = st_q.mode == tosac_pkg::MODE_CAPTURE;
    trig_edge = st_q.trig_fall ? (st_q.trig_prev & ~external_trigger_pin)
                               : (~st_q.trig_prev & external_trigger_pin);
    // Pin level read directly, so self-driven transitions also capture
    cap_lvl = st_q.cap_sel ? capture_pin_second : capture_pin_first;
    case (st_q.pin_fn)
      tosac_pkg::PF_RISE: begin
        cap_edge = cap_lvl & ~st_q.cap_prev;
      end
      tosac_pkg::PF_FALL: begin
        cap_edge = ~cap_lvl & st_q.cap_prev;
      end
      tosac_pkg::PF_BOTH: begin
        cap_edge = cap_lvl ^ st_q.cap_prev;
      end
      default: begin
        cap_edge = 1'b0;
      end
    endcase
    st_d.trig_prev = external_trigger_pin;
    st_d.cap_prev = cap_lvl;
    count_en = st_q.run && tick;
    nxt = st_q.count + 10'h001;
    match_a = sp && count_en && st_q.count == st_q.cmp_a;
    // Period gives the top three bits of the wrap point, low seven bits zero; zero means full range
    if (st_q.period == 3'h0) begin
      per_match = cap && count_en && st_q.count == tosac_pkg::CNT_MAX;
    end else begin
      per_match = cap && count_en && nxt[9:7] == st_q.period && nxt[6:0] == 7'h00;
    end
    // Register port writes
    wr_c0 = bus_req.wr && bus_req.addr == tosac_pkg::OFF_CTRL0;
    wr_c1 = bus_req.wr && bus_req.addr == tosac_pkg::OFF_CTRL1;
    wr_cmpa = bus_req.wr && bus_req.addr == tosac_pkg::OFF_CMPA;
    wr_clr = bus_req.wr && bus_req.addr == tosac_pkg::OFF_CLR;
    if (wr_c0) begin
      st_d.run = w[tosac_pkg::C0_RUN];
      st_d.period = w[tosac_pkg::C0_PER +: 3];
      st_d.clk_sel = w[tosac_pkg::C0_CLK +: 2];
    end
    if (wr_c1) begin
      st_d.mode = w[tosac_pkg::C1_MODE +: 2];
      st_d.pin_fn = w[tosac_pkg::C1_PFN +: 2];
      st_d.out_init = w[tosac_pkg::C1_OINIT];
      st_d.out_pol = w[tosac_pkg::C1_OPOL];
      st_d.swap = w[tosac_pkg::C1_SWAP];
      st_d.clr_sel = w[tosac_pkg::C1_CLRSEL];
      st_d.cap_sel = w[tosac_pkg::C1_CAPSEL];
      st_d.trig_fall = w[tosac_pkg::C1_TFALL];
    end
    if (wr_cmpa) begin
      st_d.cmp_a = w[9:0];
    end
    if (bus_req.wr && bus_req.addr == tosac_pkg::OFF_IEN) begin
      st_d.irq_en = w[1:0];
    end
    // Counting; swap and clear select never enter here
    if (match_a) begin
      st_d.run = 1'b0;
    end else if (count_en && (sp || cap)) begin
      st_d.count = per_match ? 10'h000 : nxt;
    end
    // Trigger edge wins over any clear in the same cycle
    if (sp && trig_edge) begin
      st_d.run = 1'b1;
    end
    // Apart from a period match, only a rising run bit zeroes the counter
    if (!st_q.run && st_d.run) begin
      st_d.count = 10'h000;
    end
    // A capture beats a software write of compare A
    if (cap && cap_edge) begin
      st_d.cmp_a = st_q.count;
    end
    // Sticky flags: clear first so a same-cycle event survives
    if (wr_clr) begin
      st_d.stat = st_q.stat & ~w[1:0];
    end
    if (match_a || (cap && cap_edge)) begin
      st_d.stat[tosac_pkg::ST_A] = 1'b1;
    end
    if (per_match) begin
      st_d.stat[tosac_pkg::ST_P] = 1'b1;
    end
    st_d.irq = |(st_d.stat & st_d.irq_en);
    // Pulse pin from the next run bit; capture drives nothing
    st_d.out_en = st_d.mode == tosac_pkg::MODE_PULSE
                  && st_d.pin_fn == tosac_pkg::PF_PULSE;
    if (st_d.out_en) begin
      st_d.timer_out = (st_d.run ? st_d.out_init : ~st_d.out_init) ^ st_d.out_pol;
    end else begin
      st_d.timer_out = 1'b0;
    end
    // Read data stand one cycle only; unmapped reads give zero
    st_d.rd_data = tosac_pkg::RST_WORD;
    if (bus_req.rd) begin
      case (bus_req.addr)
        tosac_pkg::OFF_CTRL0: begin
          st_d.rd_data = {10'h000, st_q.clk_sel, st_q.period, st_q.run};
        end
        tosac_pkg::OFF_CTRL1: begin
          st_d.rd_data = {6'h00, st_q.trig_fall, st_q.cap_sel, st_q.clr_sel, st_q.swap,
                          st_q.out_pol, st_q.out_init, st_q.pin_fn, st_q.mode};
        end
        tosac_pkg::OFF_COUNT: begin
          st_d.rd_data = {6'h00, st_q.count};
        end
        tosac_pkg::OFF_CMPA: begin
          st_d.rd_data = {6'h00, st_q.cmp_a};
        end
        tosac_pkg::OFF_STAT: begin
          st_d.rd_data = {14'h0000, st_q.stat};
        end
        tosac_pkg::OFF_IEN: begin
          st_d.rd_data = {14'h0000, st_q.irq_en};
        end
        default: begin
          st_d.rd_data = tosac_pkg::RST_WORD;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_ok_b) begin
    if (!rst_ok_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data = st_q.rd_data;
  assign timer_out = st_q.timer_out;
  assign timer_out_en = st_q.out_en;
  assign irq = st_q.irq;

  // Checks on the pulse path
  sequence sw_stop_s;
    wr_c0 && !bus_req.wdata[tosac_pkg::C0_RUN] && !trig_edge;
  endsequence

  sequence run_start_s;
    !st_q.run ##1 st_q.run;
  endsequence

  pulse_pin_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    sp |-> st_q.out_en && st_q.timer_out == ((st_q.run ? st_q.out_init : ~st_q.out_init)
                                             ^ st_q.out_pol))
    else $error("pulse pin level wrong");

  run_zero_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    run_start_s |-> st_q.count == 10'h000)
    else $error("counter not zero at start");

  trig_start_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    sp && trig_edge && !wr_c1 |=> st_q.run && timer_out_en_chk())
    else $error("trigger did not start pulse");

  sw_stop_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    (sp && !wr_c1) and sw_stop_s |=> !st_q.run
      && st_q.timer_out == (~st_q.out_init ^ st_q.out_pol))
    else $error("software clear did not end pulse");

  match_end_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    match_a && !trig_edge && !wr_c0 |=> !st_q.run && st_q.stat[tosac_pkg::ST_A]
      && $stable(st_q.count))
    else $error("compare A did not end pulse");

  sp_count_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    sp && count_en && !match_a && !wr_c0 && !trig_edge
      |=> st_q.count == 10'($past(st_q.count) + 10'h001))
    else $error("single pulse count disturbed");

  // Checks on the capture path
  cap_copy_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    cap && cap_edge |=> st_q.cmp_a == $past(st_q.count) && st_q.stat[tosac_pkg::ST_A])
    else $error("capture not latched");

  cap_off_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    cap && st_q.pin_fn == tosac_pkg::PF_PULSE && !wr_cmpa |=> $stable(st_q.cmp_a))
    else $error("capture while disabled");

  cap_run_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    cap && count_en && !per_match && !wr_c0
      |=> st_q.count == 10'($past(st_q.count) + 10'h001))
    else $error("capture counter stalled");

  per_wrap_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    per_match && !wr_c0 |=> st_q.count == 10'h000 && st_q.stat[tosac_pkg::ST_P])
    else $error("period match missed");

  full_wrap_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    cap && count_en && st_q.period == 3'h0 && st_q.count == 10'h1FF
      |-> !per_match)
    else $error("zero period wrapped early");

  cap_noout_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    cap |-> !st_q.out_en && !st_q.timer_out)
    else $error("capture drives output");

  // Edge decode per pin function, as named steps
  sequence cap_rise_s;
    cap && st_q.pin_fn == tosac_pkg::PF_RISE && cap_lvl && !st_q.cap_prev;
  endsequence

  sequence cap_fall_s;
    cap && st_q.pin_fn == tosac_pkg::PF_FALL && !cap_lvl && st_q.cap_prev;
  endsequence

  sequence cap_both_s;
    cap && st_q.pin_fn == tosac_pkg::PF_BOTH && cap_lvl != st_q.cap_prev;
  endsequence

  edge_hit_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    (cap_rise_s or cap_fall_s or cap_both_s) |=> st_q.stat[tosac_pkg::ST_A]
      && st_q.cmp_a == $past(st_q.count))
    else $error("active edge not captured");

  rise_miss_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    cap && st_q.pin_fn == tosac_pkg::PF_RISE && !cap_lvl && !wr_cmpa |=> $stable(st_q.cmp_a))
    else $error("capture on wrong edge");

  fall_miss_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    cap && st_q.pin_fn == tosac_pkg::PF_FALL && cap_lvl && !wr_cmpa |=> $stable(st_q.cmp_a))
    else $error("capture on wrong edge");

  // Pin enable must track the mode decode, never lag it
  out_mode_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    st_q.out_en == sp)
    else $error("output enable off mode");

  sp_hold_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    sp && !st_q.run && !trig_edge && !wr_c0 |=> $stable(st_q.count))
    else $error("stopped pulse counter moved");

  sp_noper_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    sp |-> !per_match)
    else $error("period compare active in pulse");

  pol_rest_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    sp && !st_q.run |-> st_q.timer_out == (~st_q.out_init ^ st_q.out_pol))
    else $error("idle pulse pin not inactive");

  cap_start_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    cap && !st_q.run && wr_c0 && bus_req.wdata[tosac_pkg::C0_RUN]
      |=> st_q.run && st_q.count == 10'h000)
    else $error("capture start not from zero");

  cap_hold_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    cap && !st_q.run && !wr_c0 |=> $stable(st_q.count))
    else $error("stopped capture counter moved");

  period_hit_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    cap && count_en && st_q.period != 3'h0
      && st_q.count == {3'(st_q.period - 3'h1), 7'h7F} |-> per_match)
    else $error("period boundary missed");

  full_top_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    cap && count_en && st_q.period == 3'h0 && st_q.count == tosac_pkg::CNT_MAX && !wr_c0
      |=> st_q.count == 10'h000 && st_q.stat[tosac_pkg::ST_P])
    else $error("full count did not wrap");

  // Trigger outside pulse mode must never start the counter
  trig_mode_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    !sp && !st_q.run && !wr_c0 |=> !st_q.run)
    else $error("run set outside pulse mode");

  irq_level_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    st_q.irq == |(st_q.stat & st_q.irq_en))
    else $error("interrupt level wrong");

  stat_keep_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    st_q.stat[tosac_pkg::ST_A] && !(wr_clr && bus_req.wdata[tosac_pkg::ST_A])
      |=> st_q.stat[tosac_pkg::ST_A])
    else $error("sticky flag lost");

  clr_kill_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    wr_clr && bus_req.wdata[tosac_pkg::ST_P] && !per_match |=> !st_q.stat[tosac_pkg::ST_P])
    else $error("flag clear ignored");

  // A lingering read word would alias the next read
  rd_idle_a: assert property (@(posedge clk) disable iff (!rst_ok_b)
    !bus_req.rd |=> st_q.rd_data == 16'h0000)
    else $error("read data stood too long");

  function automatic logic timer_out_en_chk();
    return st_q.out_en;
  endfunction : timer_out_en_chk
endmodule : tosac_timer
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the one-shot and capture timer.
// Assumes the far-end model drives the trigger and capture pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  tosac_pkg::tosac_bus_req_type bus_req = '0;
  logic [15:0] rd_data;
  logic trig_cmd = 1'h0;
  logic cap_cmd = 1'h0;
  logic cap_sel = 1'h0;
  logic ext_trig;
  logic cap0;
  logic cap1;
  logic timer_out;
  logic timer_out_en;
  logic irq;
  logic rd_due = 1'h0;
  logic hit;
  logic [15:0] last_rd;
  logic [15:0] prev;
  logic [15:0] exp_q[$];
  logic [15:0] mask_q[$];
  logic [9:0] cmpa_n;
  logic [9:0] lo;
  int fail_count = 0;
  int checks_done = 0;
  int seed = 32'hBEC3C74B;
  int cycles = 0;
  int width;

  always #4 clk = ~clk;

  tosac_timer tosac_timer_inst (.clk(clk), .rst_b(rst_b), .bus_req(bus_req),
    .rd_data(rd_data), .external_trigger_pin(ext_trig), .capture_pin_first(cap0),
    .capture_pin_second(cap1), .timer_out(timer_out), .timer_out_en(timer_out_en),
    .irq(irq));
  tosac_far_end tosac_far_end_inst (.clk(clk), .trig_cmd(trig_cmd), .cap_cmd(cap_cmd),
    .cap_sel(cap_sel), .external_trigger_pin(ext_trig), .capture_pin_first(cap0),
    .capture_pin_second(cap1));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
  endtask : wr

  // Expected word queued here, compared by the monitor below
  task automatic rd(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge clk);
    bus_req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 16'h0000};
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    #1;
  endtask : rd

  task automatic fire(input logic trig);
    @(posedge clk);
    trig_cmd <= trig;
    cap_cmd <= !trig;
    @(posedge clk);
    trig_cmd <= 1'h0;
    cap_cmd <= 1'h0;
  endtask : fire

  // Counts cycles of active output; bounded so a stuck pin cannot hang
  task automatic measure(output int w);
    int n;
    w = 0;
    n = 0;
    @(negedge clk);
    while (timer_out !== 1'h1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    while (timer_out === 1'h1 && w < 2000) begin
      @(negedge clk);
      w++;
    end
  endtask : measure

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) rd_due <= bus_req.rd;
  always @(negedge clk) begin
    if (rd_due) begin
      last_rd = rd_data;
      chk("read data", exp_q.pop_front(), rd_data & mask_q.pop_front());
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'h1;
    repeat (4) @(posedge clk);
    for (int a = 0; a < 8; a++) rd(a[2:0], 16'h0000, 16'hFFFF);
    // Width above 128 so an active period compare would show
    cmpa_n = 10'h081 + {3'h0, 7'($random(seed))};
    wr(tosac_pkg::OFF_CMPA, {6'h00, cmpa_n});
    wr(tosac_pkg::OFF_IEN, 16'h0003);
    wr(tosac_pkg::OFF_CTRL1, 16'h00DE);
    wr(tosac_pkg::OFF_CTRL0, 16'h0003);
    chk("out enable", 16'h0001, {15'h0000, timer_out_en});
    measure(width);
    chk("sw pulse width", {6'h00, cmpa_n} + 16'h0001, 16'(width));
    rd(tosac_pkg::OFF_CTRL0, 16'h0002, 16'hFFFF);
    rd(tosac_pkg::OFF_STAT, 16'h0001, 16'hFFFF);
    chk("irq after match", 16'h0001, {15'h0000, irq});
    wr(tosac_pkg::OFF_CLR, 16'h0003);
    @(negedge clk);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    wr(tosac_pkg::OFF_CTRL0, 16'h0001);
    repeat (5) @(posedge clk);
    wr(tosac_pkg::OFF_CTRL0, 16'h0000);
    @(negedge clk);
    chk("sw stop", 16'h0000, {15'h0000, timer_out});
    rd(tosac_pkg::OFF_STAT, 16'h0000, 16'hFFFF);
    // Trigger starts: falling edge selected, then rising with irq masked
    wr(tosac_pkg::OFF_CTRL1, 16'h021E);
    fire(1'h1);
    measure(width);
    chk("fall trig width", {6'h00, cmpa_n} + 16'h0001, 16'(width));
    wr(tosac_pkg::OFF_CLR, 16'h0003);
    wr(tosac_pkg::OFF_IEN, 16'h0000);
    wr(tosac_pkg::OFF_CTRL1, 16'h001E);
    fire(1'h1);
    measure(width);
    chk("rise trig width", {6'h00, cmpa_n} + 16'h0001, 16'(width));
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wr(tosac_pkg::OFF_IEN, 16'h0003);
    @(negedge clk);
    chk("irq enabled", 16'h0001, {15'h0000, irq});
    // Capture: every pin function code on both pins, both edges
    prev = {6'h00, cmpa_n};
    for (int pf = 0; pf < 4; pf++) begin
      for (int s = 0; s < 2; s++) begin
        cap_sel <= s[0];
        wr(tosac_pkg::OFF_CTRL1, 16'h0031 | 16'(pf << 2) | 16'(s << 8));
        @(negedge clk);
        chk("no output", 16'h0000, {15'h0000, timer_out_en | timer_out});
        for (int e = 0; e < 2; e++) begin
          hit = (pf == 2) || (pf == e);
          wr(tosac_pkg::OFF_CLR, 16'h0003);
          wr(tosac_pkg::OFF_CTRL0, 16'h0000);
          wr(tosac_pkg::OFF_CTRL0, 16'h0001);
          rd(tosac_pkg::OFF_COUNT, 16'h0000, 16'h0000);
          lo = last_rd[9:0];
          fire(1'h0);
          repeat (2) @(posedge clk);
          rd(tosac_pkg::OFF_STAT, {15'h0000, hit}, 16'h0001);
          rd(tosac_pkg::OFF_CMPA, prev, hit ? 16'h0000 : 16'hFFFF);
          prev = last_rd;
          chk("capture after start", {15'h0000, hit}, {15'h0000, hit && prev[9:0] > lo});
          rd(tosac_pkg::OFF_COUNT, 16'h0000, 16'h0000);
          chk("count runs on", 16'h0001, {15'h0000, last_rd > prev});
        end
      end
    end
    // Period 1 wraps at 128; period 0 runs the full 1024 counts
    wr(tosac_pkg::OFF_CTRL0, 16'h0000);
    wr(tosac_pkg::OFF_CLR, 16'h0003);
    wr(tosac_pkg::OFF_CTRL0, 16'h0003);
    repeat (140) @(posedge clk);
    rd(tosac_pkg::OFF_STAT, 16'h0002, 16'h0002);
    chk("period irq", 16'h0001, {15'h0000, irq});
    rd(tosac_pkg::OFF_COUNT, 16'h0000, 16'hFF80);
    wr(tosac_pkg::OFF_CTRL0, 16'h0000);
    wr(tosac_pkg::OFF_CLR, 16'h0003);
    wr(tosac_pkg::OFF_CTRL0, 16'h0001);
    repeat (600) @(posedge clk);
    rd(tosac_pkg::OFF_STAT, 16'h0000, 16'h0002);
    rd(tosac_pkg::OFF_COUNT, 16'h0000, 16'h0000);
    chk("count past 128", 16'h0001, {15'h0000, last_rd > 16'h0080});
    chk("full count", 16'h0001, {15'h0000, last_rd > 16'h0200});
    repeat (450) @(posedge clk);
    rd(tosac_pkg::OFF_STAT, 16'h0002, 16'h0002);
    conclude();
  end
endmodule : tb
`default_nettype wire

// ==== tb/tosac_far_end.sv ====
// Far-side model: trigger source and measured signal for the timer.
// Assumes one-cycle command pulses from the bench, all on clk.
`timescale 1ns/1ps
`default_nettype none
module tosac_far_end (
  input wire logic clk,
  input wire logic trig_cmd,
  input wire logic cap_cmd,
  input wire logic cap_sel,
  output logic external_trigger_pin,
  output logic capture_pin_first,
  output logic capture_pin_second
);
  logic [1:0] hold_q = 2'h0;
  initial begin
    external_trigger_pin = 1'h0;
    capture_pin_first = 1'h0;
    capture_pin_second = 1'h0;
  end
  // Trigger held three cycles so both edges reach the timer
  always @(posedge clk) begin
    if (trig_cmd) begin
      external_trigger_pin <= 1'h1;
      hold_q <= 2'h3;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
      external_trigger_pin <= (hold_q != 2'h1);
    end
    // Measured signal toggles on the chosen pin only
    if (cap_cmd && !cap_sel) capture_pin_first <= !capture_pin_first;
    if (cap_cmd && cap_sel) capture_pin_second <= !capture_pin_second;
  end
endmodule : tosac_far_end
`default_nettype wire
